// ---- fcl_fuse_loader.sv ----
`timescale 1ns/1ns
module fcl_fuse_loader
	import fcl_pkg::*;
#(
	parameter int CYC_PER_MS = FCL_CYC_PER_MS
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic powerOnReset,
	// fuse array, read as bytes
	input wire logic [8*16-1:0] fuseBytes,
	input wire logic [7:0] cal16Factory,
	input wire logic [3:0] cal16Temp,
	input wire logic [7:0] cal20Factory,
	input wire logic [3:0] cal20Temp,
	// cpu fuse read port
	input wire logic [3:0] readAddr,
	output logic [7:0] readData,
	// targets
	output fcl_watchdog_t watchdogCfg,
	output fcl_brownout_t brownoutCfg,
	output fcl_osc_t oscillator_config_fuse,
	output fcl_tmr_t timerFaultCfg,
	output fcl_sys_t systemCfg,
	output logic loadStrobe,
	output logic loadIsPowerOn,
	output logic startupDone
);
	typedef enum logic [1:0] {FCL_IDLE, FCL_WAIT, FCL_LOAD, FCL_RUN} fcl_state_t;

	fcl_state_t state;
	fcl_state_t next_state;
	logic porSeen;
	logic next_porSeen;
	logic delayStart;
	logic delayDone;
	logic [7:0] fuseMem [16];
	fcl_watchdog_t next_watchdogCfg;
	fcl_brownout_t next_brownoutCfg;
	fcl_osc_t next_oscillator_config_fuse;
	fcl_tmr_t next_timerFaultCfg;
	fcl_sys_t next_systemCfg;
	logic next_loadStrobe;
	logic next_loadIsPowerOn;
	logic next_startupDone;
	logic [7:0] next_readData;

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_fuse
			assign fuseMem[gi] = fuseBytes[8*gi +: 8];
		end
	endgenerate

	fcl_delay_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) uDelay (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(delayStart),
		.delaySel(fuseMem[FCL_OFS_SYSB][2:0]),
		.done(delayDone)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: reset -> start-up delay -> load -> run

	always_comb begin
		next_state = state;
		next_porSeen = porSeen;
		delayStart = 1'b0;
		unique case (state)
			FCL_IDLE: begin
				delayStart = 1'b1;
				next_state = FCL_WAIT;
			end
			FCL_WAIT: begin
				if (delayDone) begin
					next_state = FCL_LOAD;
				end
			end
			FCL_LOAD: begin
				next_state = FCL_RUN;
				next_porSeen = 1'b0;
			end
			FCL_RUN: begin
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= FCL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// power-on flag is captured while reset is asserted, held until load
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			porSeen <= powerOnReset;
		end else begin
			porSeen <= next_porSeen;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// target values; brown-out and timer fault settings survive non-power-on resets

	always_comb begin
		next_watchdogCfg = watchdogCfg;
		next_brownoutCfg = brownoutCfg;
		next_oscillator_config_fuse = oscillator_config_fuse;
		next_timerFaultCfg = timerFaultCfg;
		next_systemCfg = systemCfg;
		next_loadStrobe = 1'b0;
		next_loadIsPowerOn = loadIsPowerOn;
		next_startupDone = startupDone;
		if (state == FCL_LOAD) begin
			next_loadStrobe = 1'b1;
			next_loadIsPowerOn = porSeen;
			next_startupDone = 1'b1;
			next_watchdogCfg.window = fuseMem[FCL_OFS_WATCHDOG][7:4];
			next_watchdogCfg.period = fuseMem[FCL_OFS_WATCHDOG][3:0];
			if (porSeen) begin
				next_brownoutCfg = fcl_brownout_t'(fuseMem[FCL_OFS_BROWNOUT]);
				if (fuseMem[FCL_OFS_BROWNOUT][1:0] == FCL_SLEEP_RESERVED) begin
					next_brownoutCfg.sleep = 2'h0;
				end
				next_timerFaultCfg = fcl_tmr_t'(fuseMem[FCL_OFS_TMR]);
			end
			next_oscillator_config_fuse.calLock = fuseMem[FCL_OFS_OSC][7];
			next_oscillator_config_fuse.osc_frequency_select = fuseMem[FCL_OFS_OSC][1:0];
			if (fuseMem[FCL_OFS_OSC][1:0] == FCL_FREQ_16M) begin
				next_oscillator_config_fuse.factoryCal = cal16Factory;
				next_oscillator_config_fuse.tempCal = cal16Temp;
			end else begin
				next_oscillator_config_fuse.factoryCal = cal20Factory;
				next_oscillator_config_fuse.tempCal = cal20Temp;
			end
			next_systemCfg.crcSource = fuseMem[FCL_OFS_SYSA][7:6];
			next_systemCfg.resetPinFunction = fuseMem[FCL_OFS_SYSA][3:2];
			next_systemCfg.locked = (fuseMem[FCL_OFS_LOCK] != FCL_OPEN_CODE);
			next_systemCfg.eepromKeepOnErase = fuseMem[FCL_OFS_SYSA][0] &
				(fuseMem[FCL_OFS_LOCK] == FCL_OPEN_CODE);
			next_systemCfg.startupDelay = fuseMem[FCL_OFS_SYSB][2:0];
		end
	end

	always_comb begin
		next_readData = 8'h00;
		if (readAddr < FCL_NUM_FUSES && readAddr != FCL_OFS_SPARE_A && readAddr != FCL_OFS_SPARE_B) begin
			next_readData = fuseMem[readAddr];
		end
	end

	// brown-out and timer fault settings hold across ordinary resets; only a power-on clears them
	always_ff @(posedge clock) begin
		if (sys_rst && powerOnReset) begin
			brownoutCfg <= '0;
			timerFaultCfg <= '0;
		end else begin
			brownoutCfg <= next_brownoutCfg;
			timerFaultCfg <= next_timerFaultCfg;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			watchdogCfg <= '0;
			oscillator_config_fuse <= '0;
			systemCfg <= '0;
			systemCfg.crcSource <= FCL_CRC_NONE;
			systemCfg.resetPinFunction <= FCL_SYSA_RESET[3:2];
			loadStrobe <= 1'b0;
			loadIsPowerOn <= 1'b0;
			startupDone <= 1'b0;
			readData <= 8'h00;
		end else begin
			watchdogCfg <= next_watchdogCfg;
			oscillator_config_fuse <= next_oscillator_config_fuse;
			systemCfg <= next_systemCfg;
			loadStrobe <= next_loadStrobe;
			loadIsPowerOn <= next_loadIsPowerOn;
			startupDone <= next_startupDone;
			readData <= next_readData;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_watchdog_load;
		@(posedge clock) disable iff (sys_rst)
		state == FCL_LOAD |=> watchdogCfg == fuseMem[FCL_OFS_WATCHDOG];
	endproperty
	a_watchdog_load: assert property (p_watchdog_load) else $error("watchdog not loaded from fuse");

	property p_watchdog_period;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> watchdogCfg.period == fuseMem[FCL_OFS_WATCHDOG][3:0];
	endproperty
	a_watchdog_period: assert property (p_watchdog_period) else $error("period mismatch");

	property p_brownout_hold;
		@(posedge clock) disable iff (sys_rst)
		state == FCL_LOAD && !porSeen |=> $stable(brownoutCfg) && $stable(timerFaultCfg);
	endproperty
	a_brownout_hold: assert property (p_brownout_hold) else $error("config changed on warm reset");

	property p_brownout_level;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn |-> brownoutCfg.level == fuseMem[FCL_OFS_BROWNOUT][7:5]
			&& brownoutCfg.sampleRate == fuseMem[FCL_OFS_BROWNOUT][4];
	endproperty
	a_brownout_level: assert property (p_brownout_level) else $error("brown-out level or rate wrong");

	property p_brownout_active;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn |-> brownoutCfg.active == fuseMem[FCL_OFS_BROWNOUT][3:2];
	endproperty
	a_brownout_active: assert property (p_brownout_active) else $error("active mode wrong");

	property p_sleep_copy;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn && fuseMem[FCL_OFS_BROWNOUT][1:0] != FCL_SLEEP_RESERVED
			|-> brownoutCfg.sleep == fuseMem[FCL_OFS_BROWNOUT][1:0];
	endproperty
	a_sleep_copy: assert property (p_sleep_copy) else $error("sleep mode wrong");

	property p_sleep_legal;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> brownoutCfg.sleep != FCL_SLEEP_RESERVED;
	endproperty
	a_sleep_legal: assert property (p_sleep_legal) else $error("reserved sleep code loaded");

	property p_osc_lock;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> oscillator_config_fuse.calLock == fuseMem[FCL_OFS_OSC][7]
			&& (oscillator_config_fuse.osc_frequency_select != FCL_FREQ_16M || oscillator_config_fuse.factoryCal == cal16Factory);
	endproperty
	a_osc_lock: assert property (p_osc_lock) else $error("oscillator config wrong");

	property p_tmr_load;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn |-> timerFaultCfg == fuseMem[FCL_OFS_TMR];
	endproperty
	a_tmr_load: assert property (p_tmr_load) else $error("timer fault control wrong");

	property p_lock;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> systemCfg.locked == (fuseMem[FCL_OFS_LOCK] != FCL_OPEN_CODE)
			&& (!systemCfg.locked || !systemCfg.eepromKeepOnErase);
	endproperty
	a_lock: assert property (p_lock) else $error("lock or eeprom keep wrong");

	property p_load_once;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |=> !loadStrobe [*2];
	endproperty
	a_load_once: assert property (p_load_once) else $error("load repeated");

	property p_rate_copy;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn |-> brownoutCfg.sampleRate == fuseMem[FCL_OFS_BROWNOUT][4];
	endproperty
	a_rate_copy: assert property (p_rate_copy) else $error("sample rate wrong");

	property p_osc_cal;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> oscillator_config_fuse.osc_frequency_select == fuseMem[FCL_OFS_OSC][1:0]
			&& {oscillator_config_fuse.factoryCal, oscillator_config_fuse.tempCal} == ((oscillator_config_fuse.osc_frequency_select == FCL_FREQ_16M) ?
			{cal16Factory, cal16Temp} : {cal20Factory, cal20Temp});
	endproperty
	a_osc_cal: assert property (p_osc_cal) else $error("oscillator calibration wrong");

	property p_timer_pins;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn |-> timerFaultCfg.pinEnable == fuseMem[FCL_OFS_TMR][7:4];
	endproperty
	a_timer_pins: assert property (p_timer_pins) else $error("compare pin enables wrong");

	property p_timer_levels;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && loadIsPowerOn |-> timerFaultCfg.defaultLevel == fuseMem[FCL_OFS_TMR][3:0];
	endproperty
	a_timer_levels: assert property (p_timer_levels) else $error("compare default levels wrong");

	property p_timer_hold;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe && !loadIsPowerOn |-> $stable(timerFaultCfg);
	endproperty
	a_timer_hold: assert property (p_timer_hold) else $error("timer settings changed on warm load");

	property p_crc_source;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> systemCfg.crcSource == fuseMem[FCL_OFS_SYSA][7:6];
	endproperty
	a_crc_source: assert property (p_crc_source) else $error("crc source wrong");

	property p_reset_pin;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> systemCfg.resetPinFunction == fuseMem[FCL_OFS_SYSA][3:2];
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin function wrong");

	property p_eeprom_keep;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> systemCfg.eepromKeepOnErase ==
			(fuseMem[FCL_OFS_SYSA][0] && fuseMem[FCL_OFS_LOCK] == FCL_OPEN_CODE);
	endproperty
	a_eeprom_keep: assert property (p_eeprom_keep) else $error("eeprom keep wrong");

	property p_startup_delay;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> systemCfg.startupDelay == fuseMem[FCL_OFS_SYSB][2:0];
	endproperty
	a_startup_delay: assert property (p_startup_delay) else $error("start-up delay wrong");

	property p_power_on_flag;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> loadIsPowerOn == $past(porSeen);
	endproperty
	a_power_on_flag: assert property (p_power_on_flag) else $error("power-on flag wrong");

	property p_startup_done;
		@(posedge clock) disable iff (sys_rst)
		loadStrobe |-> startupDone;
	endproperty
	a_startup_done: assert property (p_startup_done) else $error("start-up not marked done");
endmodule

// ---- fcl_pkg.sv ----
package fcl_pkg;
	localparam logic [3:0] FCL_OFS_WATCHDOG = 4'h0;
	localparam logic [3:0] FCL_OFS_BROWNOUT = 4'h1;
	localparam logic [3:0] FCL_OFS_OSC = 4'h2;
	localparam logic [3:0] FCL_OFS_TMR = 4'h4;
	localparam logic [3:0] FCL_OFS_SYSA = 4'h5;
	localparam logic [3:0] FCL_OFS_SYSB = 4'h6;
	localparam logic [3:0] FCL_OFS_APP = 4'h7;
	localparam logic [3:0] FCL_OFS_BOOT = 4'h8;
	localparam logic [3:0] FCL_OFS_LOCK = 4'ha;
	// unused offsets, read back as zero
	localparam logic [3:0] FCL_OFS_SPARE_A = 4'h3;
	localparam logic [3:0] FCL_OFS_SPARE_B = 4'h9;
	localparam logic [3:0] FCL_NUM_FUSES = 4'hb;
	localparam logic [7:0] FCL_SYSA_RESET = 8'hc4;
	localparam logic [7:0] FCL_OPEN_CODE = 8'hc5;
	localparam logic [1:0] FCL_FREQ_16M = 2'h1;
	localparam logic [1:0] FCL_FREQ_20M = 2'h2;
	localparam logic [1:0] FCL_RSTPIN_RESERVED = 2'h3;
	localparam logic [1:0] FCL_SLEEP_RESERVED = 2'h3;
	localparam logic [1:0] FCL_CRC_NONE = 2'h3;
	localparam logic [2:0] FCL_DELAY_SEL_MAX = 3'h7;
	// start-up delay unit and cycles per millisecond at 125 MHz
	localparam int FCL_MS_UNIT = 1;
	localparam int FCL_CLK_MHZ = 125;
	localparam int FCL_CYC_PER_MS = FCL_MS_UNIT * FCL_CLK_MHZ * 1000;
	typedef struct packed {
		logic [3:0] window;
		logic [3:0] period;
	} fcl_watchdog_t;
	typedef struct packed {
		logic [2:0] level;
		logic sampleRate;
		logic [1:0] active;
		logic [1:0] sleep;
	} fcl_brownout_t;
	typedef struct packed {
		logic calLock;
		logic [1:0] osc_frequency_select;
		logic [7:0] factoryCal;
		logic [3:0] tempCal;
	} fcl_osc_t;
	typedef struct packed {
		logic [3:0] pinEnable;
		logic [3:0] defaultLevel;
	} fcl_tmr_t;
	typedef struct packed {
		logic [1:0] crcSource;
		logic [1:0] resetPinFunction;
		logic eepromKeepOnErase;
		logic [2:0] startupDelay;
		logic locked;
	} fcl_sys_t;
endpackage

// ---- fcl_delay_timer.sv ----
`timescale 1ns/1ns
module fcl_delay_timer
	import fcl_pkg::*;
#(
	parameter int CYC_PER_MS = FCL_CYC_PER_MS
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// control
	input wire logic start,
	input wire logic [2:0] delaySel,
	// status
	output logic done
);
	logic [6:0] msLeft;
	logic [6:0] next_msLeft;
	logic [23:0] cyc;
	logic [23:0] next_cyc;
	logic running;
	logic next_running;
	logic next_done;
	logic msTick;

	assign msTick = (cyc == 24'(CYC_PER_MS - 1));

	always_comb begin
		next_msLeft = msLeft;
		next_cyc = cyc;
		next_running = running;
		next_done = 1'b0;
		if (start) begin
			next_msLeft = (delaySel == 3'h0) ? 7'h00 : 7'(7'h01 << (delaySel - 3'h1));
			next_cyc = 24'h000000;
			next_running = 1'b1;
		end else if (running) begin
			if (msLeft == 7'h00) begin
				next_running = 1'b0;
				next_done = 1'b1;
			end else if (msTick) begin
				next_cyc = 24'h000000;
				next_msLeft = msLeft - 7'h01;
			end else begin
				next_cyc = cyc + 24'h000001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			msLeft <= 7'h00;
			cyc <= 24'h000000;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			msLeft <= next_msLeft;
			cyc <= next_cyc;
			running <= next_running;
			done <= next_done;
		end
	end

	property p_delay_len;
		@(posedge clock) disable iff (sys_rst)
		start && delaySel == 3'h0 |-> ##2 done;
	endproperty
	a_delay_len: assert property (p_delay_len) else $error("zero delay did not finish in two cycles");
endmodule

// ---- fcl_target_regs.sv ----
`timescale 1ns/1ns
module fcl_target_regs
	import fcl_pkg::*;
(
	// clock
	input wire logic clock,
	// load from the fuse loader
	input wire logic loadStrobe,
	input wire logic loadIsPowerOn,
	input wire fcl_watchdog_t watchdogCfg,
	input wire fcl_brownout_t brownoutCfg,
	input wire fcl_tmr_t timerFaultCfg,
	// held target registers
	output fcl_watchdog_t watchdogReg,
	output fcl_brownout_t brownoutReg,
	output fcl_tmr_t tmrReg
);
	////////////////////////////////////////////////////////////////
	// targets take values only in the strobe cycle
	always_ff @(posedge clock) begin
		if (loadStrobe) begin
			watchdogReg <= watchdogCfg;
			// brown-out and timer keep their settings unless power-on
			if (loadIsPowerOn) begin
				brownoutReg <= brownoutCfg;
				tmrReg <= timerFaultCfg;
			end
		end
	end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	import fcl_pkg::*;
	localparam int CPM = 4;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic powerOnReset = 1'b1;
	logic [8*16-1:0] fuseBytes = '0;
	logic [3:0] readAddr = 4'h0;
	logic [7:0] readData;
	fcl_watchdog_t watchdogCfg;
	fcl_brownout_t brownoutCfg;
	fcl_osc_t oscillator_config_fuse;
	fcl_tmr_t timerFaultCfg;
	fcl_sys_t systemCfg;
	logic loadStrobe;
	logic loadIsPowerOn;
	logic startupDone;
	fcl_watchdog_t watchdogReg;
	fcl_brownout_t brownoutReg;
	fcl_tmr_t tmrReg;
	fcl_brownout_t expBrownout;
	fcl_tmr_t expTmr;
	int n_mismatch = 0;
	int n_compared = 0;

	always #4 clock = ~clock;

	////////////////////////////////////////////////////////////////
	fcl_fuse_loader #(.CYC_PER_MS(CPM)) fcl_fuse_loader_inst (
		.clock(clock), .sys_rst(sys_rst), .powerOnReset(powerOnReset), .fuseBytes(fuseBytes),
		.cal16Factory(8'h5a), .cal16Temp(4'h3), .cal20Factory(8'ha7), .cal20Temp(4'hc),
		.readAddr(readAddr), .readData(readData), .watchdogCfg(watchdogCfg),
		.brownoutCfg(brownoutCfg), .oscillator_config_fuse(oscillator_config_fuse), .timerFaultCfg(timerFaultCfg),
		.systemCfg(systemCfg), .loadStrobe(loadStrobe), .loadIsPowerOn(loadIsPowerOn),
		.startupDone(startupDone));

	fcl_target_regs fcl_target_regs_inst (
		.clock(clock), .loadStrobe(loadStrobe), .loadIsPowerOn(loadIsPowerOn),
		.watchdogCfg(watchdogCfg), .brownoutCfg(brownoutCfg), .timerFaultCfg(timerFaultCfg),
		.watchdogReg(watchdogReg), .brownoutReg(brownoutReg), .tmrReg(tmrReg));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one reset, one load, then all targets and the read port
	task automatic run(input logic por, input logic [7:0] w, b, o, t, s0, s1, lk);
		int n;
		int d;
		logic [7:0] e;
		@(posedge clock);
		sys_rst <= 1'b1;
		powerOnReset <= por;
		fuseBytes <= {40'h0, lk, 8'hff, 8'h33, 8'h22, s1, s0, t, 8'hff, o, b, w};
		repeat (16) @(posedge clock);
		#1;
		if (por) begin
			expBrownout = '0;
			expTmr = '0;
		end
		check(systemCfg, 9'h1a0);
		check(brownoutCfg, expBrownout);
		check(timerFaultCfg, expTmr);
		@(posedge clock);
		sys_rst <= 1'b0;
		n = 0;
		while (loadStrobe !== 1'b1 && n < 1000) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 1000) begin
			n_mismatch++;
			end_of_test();
		end
		d = (s1[2:0] == 3'h0) ? 0 : (CPM << (s1[2:0] - 1));
		check(n >= d + 2 && n <= d + 6, 1);
		if (por) begin
			expBrownout = fcl_brownout_t'(b);
			if (expBrownout.sleep == FCL_SLEEP_RESERVED)
				expBrownout.sleep = 2'h0;
			expTmr = fcl_tmr_t'(t);
		end
		check(watchdogCfg, w);
		check(brownoutCfg, expBrownout);
		check(oscillator_config_fuse, {o[7], o[1:0], (o[1:0] == FCL_FREQ_16M) ? 12'h5a3 : 12'ha7c});
		check(timerFaultCfg, expTmr);
		check(systemCfg, {s0[7:6], s0[3:2], s0[0] & (lk == FCL_OPEN_CODE), s1[2:0], lk != FCL_OPEN_CODE});
		check(loadIsPowerOn, por);
		check(startupDone, 1'b1);
		@(posedge clock);
		#1;
		check(loadStrobe, 1'b0);
		check(watchdogReg, w);
		check(brownoutReg, expBrownout);
		check(tmrReg, expTmr);
		for (int a = 0; a < 13; a++) begin
			@(posedge clock);
			readAddr <= 4'(a);
			@(posedge clock);
			#1;
			e = (a == 3 || a == 9 || a > 10) ? 8'h00 : fuseBytes[8*a +: 8];
			check(readData, e);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		run(1'b1, 8'h5a, 8'hab, 8'h81, 8'ha5, 8'h45, 8'h00, 8'hc5);
		run(1'b0, 8'h3c, 8'h00, 8'h02, 8'h5a, 8'h89, 8'h02, 8'h00);
		run(1'b1, 8'hf0, 8'hf6, 8'h03, 8'h0f, 8'hc0, 8'h07, 8'hc4);
		run(1'b1, 8'h96, 8'h0d, 8'h00, 8'hc3, 8'h04, 8'h01, 8'hc5);
		end_of_test();
	end
endmodule
